// File: io_select_consts.vh
// Constants for the I/O select and DMA gate decoder
`ifndef IO_SELECT_CONSTS_VH
`define IO_SELECT_CONSTS_VH
`define BLOCK_SHIFT 7
`define NUM_BLOCKS 7
`define ADDR_DMA_GATE_OFF 16'h0000
`define ADDR_DMA_GATE_ON 16'h0002
`define ADDR_PRINTER_DATA 16'h0080
`define ADDR_PRINTER_CONTROL 16'h0082
`define ADDR_GENERAL_IO 16'h0100
`define ADDR_VDAC_DATA 16'h0108
`define ADDR_VDAC_ENABLE 16'h0118
`define ADDR_REFRESH_ENABLE 16'h0120
`define ADDR_LUMA_ADC 16'h0140
`define VDAC_CTRL_BITS 6
`define CLK_HZ 10000000
`define TICK_PERIOD_US 1000
`define TICK_CYCLES ((`CLK_HZ / 1000000) * `TICK_PERIOD_US)
`define LINE_REF_CYCLES 16'h0280
`define RESET_DMA_GATE 1'b0
`define RESET_VDAC_EN 1'b0
`define RESET_REFRESH_EN 1'b0
`endif

// File: io_select_dma_gate_decoder.v
// I/O select decoder, control strobes, timers and DMA gating
//
// Function
// - Seven 128-byte select blocks from zero
// - Block zero: address bit 1 gates DMA
// - Write 0 disables, write 2 enables DMA
// - Second select covers printer port space
// - Printer data, control writes; status read at data address
// - Third select; general I/O at 0x100
// - 118 read clears, write sets DAC enable
// - 120 read clears, write sets refresh enable
// - 108 loads DAC data; 140 reads luminance
// - Fourth select forwards low six address bits
// - Fifth select for SCSI daughter board
// - Sixth, seventh selects for expansion only
// - Three 16-bit timers; third internal only
// - Third timer ticks every millisecond
// - Second timer makes crystal line reference
// - First timer measures synthesized sync
// - Interrupt zero printer, one SCSI
// - Interrupts three, four go to expansion
// - DMA zero serves SCSI transfers
// - DMA one loads video row per line
// - Load word: comparator low, luminance high
// - External refresh DMA via hold handshake
// - Everything timed from one oscillator clock
`timescale 1ns/1ns
`include "io_select_consts.vh"

module io_select_dma_gate_decoder #(
    parameter TICK_CYCLES = `TICK_CYCLES,
    parameter LINE_REF_CYCLES = `LINE_REF_CYCLES
) (
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Processor I/O access, same clock
    input wire [15:0] io_addr,
    input wire [15:0] io_wdata,
    input wire io_wr,
    input wire io_rd,
    output reg [15:0] io_rdata,
    output wire io_rdata_oe_n,
    // Peripheral selects
    output wire sel_block_zero,
    output wire sel_printer_port,
    output wire sel_general_io,
    output wire sel_vertical_dac_load,
    output wire sel_scsi_board,
    output wire sel_expansion_a,
    output wire sel_expansion_b,
    output reg [5:0] vdac_ctrl_bits,
    // Printer port
    output reg [15:0] printer_data_q,
    output reg [15:0] printer_control_q,
    input wire [15:0] printer_status,
    // General I/O, vertical DAC, luminance
    input wire [15:0] gpio_in,
    output reg [15:0] gpio_out_q,
    output reg [15:0] vdac_data_q,
    output reg vdac_data_load,
    input wire [15:0] video_position,
    input wire [15:0] luma_adc,
    output reg vdac_en_q,
    output reg refresh_en_q,
    // DMA gating
    output reg dma_gate_q,
    input wire dma0_req_in,
    input wire dma1_req_in,
    output wire dma0_req,
    output wire dma1_req,
    // Line table load word
    input wire [7:0] comparator_value,
    input wire [7:0] luminance_level,
    output reg [15:0] line_load_word,
    // Timers and sync
    input wire synth_sync_pin,
    output reg [15:0] synth_sync_period_q,
    output reg crystal_line_ref,
    output reg tick_irq,
    // Interrupts
    input wire printer_port_irq_pin,
    input wire scsi_port_irq_pin,
    input wire ext_irq_three_pin,
    input wire ext_irq_four_pin,
    output wire ext_irq_zero,
    output wire ext_irq_one,
    output wire ext_irq_three,
    output wire ext_irq_four,
    // External refresh DMA
    input wire refresh_req_in,
    input wire bus_hold_ack_pin,
    output reg bus_hold_req,
    output reg line_table_refresh_cycle
);

    // ==========================================
    // Decode helpers
    function [2:0] block_of;
        input [15:0] a;
        begin
            block_of = a[9:7];
        end
    endfunction

    function in_io_map;
        input [15:0] a;
        begin
            in_io_map = (a[15:10] == 6'h00) && (a[9:7] != 3'h7);
        end
    endfunction

    // ==========================================
    // Pin synchronisers
    reg [5:0] sync1_q;
    reg [5:0] sync2_q;
    wire [5:0] pins_raw = {synth_sync_pin, printer_port_irq_pin, scsi_port_irq_pin,
                           ext_irq_three_pin, ext_irq_four_pin, bus_hold_ack_pin};

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync1_q <= 6'h00;
            sync2_q <= 6'h00;
        end else begin
            sync1_q <= pins_raw;
            sync2_q <= sync1_q;
        end
    end

    wire synth_sync_s = sync2_q[5];
    wire hold_ack_s = sync2_q[0];
    assign ext_irq_zero = sync2_q[4];
    assign ext_irq_one = sync2_q[3];
    assign ext_irq_three = sync2_q[2];
    assign ext_irq_four = sync2_q[1];

    // Port input words, two flops each before the read mux;
    // the bits are independent lines, so no word handshake is needed
    reg [15:0] gpio_meta_q;
    reg [15:0] gpio_sync_q;
    reg [15:0] status_meta_q;
    reg [15:0] status_sync_q;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            gpio_meta_q <= 16'h0000;
            gpio_sync_q <= 16'h0000;
            status_meta_q <= 16'h0000;
            status_sync_q <= 16'h0000;
        end else begin
            gpio_meta_q <= gpio_in;
            gpio_sync_q <= gpio_meta_q;
            status_meta_q <= printer_status;
            status_sync_q <= status_meta_q;
        end
    end

    // ==========================================
    // Select lines
    wire mapped = in_io_map(io_addr);
    wire [2:0] blk = block_of(io_addr);
    wire [6:0] sel_vec;
    genvar g;
    generate
        for (g = 0; g < `NUM_BLOCKS; g = g + 1) begin : gen_sel
            assign sel_vec[g] = mapped && (blk == g) && (io_wr || io_rd);
        end
    endgenerate

    assign sel_block_zero = sel_vec[0];
    assign sel_printer_port = sel_vec[1];
    assign sel_general_io = sel_vec[2];
    assign sel_vertical_dac_load = sel_vec[3];
    assign sel_scsi_board = sel_vec[4];
    assign sel_expansion_a = sel_vec[5];
    assign sel_expansion_b = sel_vec[6];

    wire wr_gio = io_wr && sel_general_io;
    wire rd_gio = io_rd && sel_general_io;

    // ==========================================
    // Control strobes and port registers
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dma_gate_q <= `RESET_DMA_GATE;
            vdac_en_q <= `RESET_VDAC_EN;
            refresh_en_q <= `RESET_REFRESH_EN;
            printer_data_q <= 16'h0000;
            printer_control_q <= 16'h0000;
            gpio_out_q <= 16'h0000;
            vdac_data_q <= 16'h0000;
            vdac_data_load <= 1'b0;
            vdac_ctrl_bits <= 6'h00;
        end else begin
            vdac_data_load <= 1'b0;
            if (io_wr && sel_block_zero) begin
                dma_gate_q <= io_addr[1];
            end
            if (io_wr && sel_printer_port) begin
                if (io_addr[1]) begin
                    printer_control_q <= io_wdata;
                end else begin
                    printer_data_q <= io_wdata;
                end
            end
            if (wr_gio && io_addr == `ADDR_GENERAL_IO) begin
                gpio_out_q <= io_wdata;
            end
            if (wr_gio && io_addr == `ADDR_VDAC_DATA) begin
                vdac_data_q <= io_wdata;
                vdac_data_load <= 1'b1;
            end
            if (io_addr == `ADDR_VDAC_ENABLE) begin
                if (wr_gio) begin
                    vdac_en_q <= 1'b1;
                end else if (rd_gio) begin
                    vdac_en_q <= 1'b0;
                end
            end
            if (io_addr == `ADDR_REFRESH_ENABLE) begin
                if (wr_gio) begin
                    refresh_en_q <= 1'b1;
                end else if (rd_gio) begin
                    refresh_en_q <= 1'b0;
                end
            end
            if (sel_vertical_dac_load) begin
                vdac_ctrl_bits <= io_addr[`VDAC_CTRL_BITS-1:0];
            end
        end
    end

    // ==========================================
    // Read data, registered; driven only for mapped reads
    reg rd_drive_q;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            io_rdata <= 16'h0000;
            rd_drive_q <= 1'b0;
        end else begin
            rd_drive_q <= 1'b0;
            io_rdata <= 16'h0000;
            if (io_rd && sel_printer_port && !io_addr[1]) begin
                io_rdata <= status_sync_q;
                rd_drive_q <= 1'b1;
            end else if (rd_gio) begin
                case (io_addr)
                    `ADDR_GENERAL_IO: begin
                        io_rdata <= gpio_sync_q;
                        rd_drive_q <= 1'b1;
                    end
                    `ADDR_VDAC_DATA: begin
                        io_rdata <= video_position;
                        rd_drive_q <= 1'b1;
                    end
                    `ADDR_LUMA_ADC: begin
                        io_rdata <= luma_adc;
                        rd_drive_q <= 1'b1;
                    end
                    default: begin
                        rd_drive_q <= 1'b0;
                    end
                endcase
            end
        end
    end
    assign io_rdata_oe_n = ~rd_drive_q;

    // ==========================================
    // DMA gating; software turns it off around critical code
    assign dma0_req = dma0_req_in && dma_gate_q;
    assign dma1_req = dma1_req_in && dma_gate_q;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            line_load_word <= 16'h0000;
        end else if (dma1_req) begin
            line_load_word <= {luminance_level, comparator_value};
        end
    end

    // ==========================================
    // Timers, all on the one clock
    reg [15:0] tick_cnt_q;
    reg [15:0] line_cnt_q;
    reg [15:0] sync_cnt_q;
    reg sync_prev_q;

    // Internal-only tick timer, one pulse per period
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tick_cnt_q <= 16'h0000;
            tick_irq <= 1'b0;
        end else begin
            tick_irq <= 1'b0;
            if (tick_cnt_q == TICK_CYCLES - 1) begin
                tick_cnt_q <= 16'h0000;
                tick_irq <= 1'b1;
            end else begin
                tick_cnt_q <= tick_cnt_q + 16'h0001;
            end
        end
    end

    // Line reference toggles from the internal clock
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            line_cnt_q <= 16'h0000;
            crystal_line_ref <= 1'b0;
        end else if (line_cnt_q == LINE_REF_CYCLES - 1) begin
            line_cnt_q <= 16'h0000;
            crystal_line_ref <= ~crystal_line_ref;
        end else begin
            line_cnt_q <= line_cnt_q + 16'h0001;
        end
    end

    // Period of synthesized sync for diagnostics; the count restarts at one
    // so that the captured value is the full number of cycles between edges
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync_cnt_q <= 16'h0000;
            sync_prev_q <= 1'b0;
            synth_sync_period_q <= 16'h0000;
        end else begin
            sync_prev_q <= synth_sync_s;
            if (synth_sync_s && !sync_prev_q) begin
                synth_sync_period_q <= sync_cnt_q;
                sync_cnt_q <= 16'h0001;
            end else if (sync_cnt_q != 16'hFFFF) begin
                sync_cnt_q <= sync_cnt_q + 16'h0001;
            end
        end
    end

    // ==========================================
    // External refresh DMA over the hold handshake; a new request
    // waits until the processor has let go of the acknowledge, so a
    // stale acknowledge is never taken for a fresh grant
    localparam HOLD_IDLE = 2'b00;
    localparam HOLD_WAIT = 2'b01;
    localparam HOLD_DONE = 2'b10;

    reg [1:0] hold_state_q;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hold_state_q <= HOLD_IDLE;
            bus_hold_req <= 1'b0;
            line_table_refresh_cycle <= 1'b0;
        end else begin
            line_table_refresh_cycle <= 1'b0;
            case (hold_state_q)
                HOLD_IDLE: begin
                    if (refresh_req_in && refresh_en_q && !hold_ack_s) begin
                        bus_hold_req <= 1'b1;
                        hold_state_q <= HOLD_WAIT;
                    end
                end
                HOLD_WAIT: begin
                    if (hold_ack_s) begin
                        line_table_refresh_cycle <= 1'b1;
                        bus_hold_req <= 1'b0;
                        hold_state_q <= HOLD_DONE;
                    end
                end
                HOLD_DONE: begin
                    if (!hold_ack_s) begin
                        hold_state_q <= HOLD_IDLE;
                    end
                end
                default: begin
                    bus_hold_req <= 1'b0;
                    hold_state_q <= HOLD_IDLE;
                end
            endcase
        end
    end

endmodule

// File: io_select_props.sv
// Checker for the I/O select and DMA gate decoder
`timescale 1ns/1ns
module io_select_props (
    // Clock, reset and access
    input wire clk,
    input wire rstn,
    input wire [15:0] io_addr,
    input wire io_wr,
    input wire io_rd,
    input wire [15:0] io_rdata,
    input wire io_rdata_oe_n,
    // Selects and strobes
    input wire sel_block_zero,
    input wire sel_expansion_b,
    input wire [5:0] vdac_ctrl_bits,
    input wire vdac_en_q,
    input wire refresh_en_q,
    input wire dma_gate_q,
    input wire dma1_req_in,
    input wire dma1_req,
    input wire [15:0] luma_adc
);
    reg [15:0] addr_q;
    always @(posedge clk) begin
        addr_q <= io_addr;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    property p_sel_zero;
        sel_block_zero == ((io_wr || io_rd) && io_addr < 16'h0080);
    endproperty
    a_sel_zero: assert property (p_sel_zero) else $error("block zero select wrong");
    property p_sel_six;
        sel_expansion_b == ((io_wr || io_rd) && io_addr >= 16'h0300 && io_addr < 16'h0380);
    endproperty
    a_sel_six: assert property (p_sel_six) else $error("expansion b select wrong");
    property p_gate;
        io_wr && io_addr < 16'h0080 |=> dma_gate_q == addr_q[1];
    endproperty
    a_gate: assert property (p_gate) else $error("dma gate not set from bit 1");
    property p_gate_hold;
        !(io_wr && io_addr < 16'h0080) |=> $stable(dma_gate_q);
    endproperty
    a_gate_hold: assert property (p_gate_hold) else $error("dma gate changed");
    property p_req;
        dma1_req == (dma1_req_in && dma_gate_q);
    endproperty
    a_req: assert property (p_req) else $error("dma request not gated");
    property p_vdac_set;
        io_wr && io_addr == 16'h0118 |=> vdac_en_q;
    endproperty
    a_vdac_set: assert property (p_vdac_set) else $error("dac enable not set");
    property p_vdac_clr;
        io_rd && !io_wr && io_addr == 16'h0118 |=> !vdac_en_q;
    endproperty
    a_vdac_clr: assert property (p_vdac_clr) else $error("dac enable not cleared");
    property p_refresh;
        io_rd && !io_wr && io_addr == 16'h0120 |=> !refresh_en_q;
    endproperty
    a_refresh: assert property (p_refresh) else $error("refresh enable not cleared");
    property p_luma;
        io_rd && !io_wr && io_addr == 16'h0140 |=> !io_rdata_oe_n && io_rdata == $past(luma_adc);
    endproperty
    a_luma: assert property (p_luma) else $error("luminance read wrong");
    property p_ctrl;
        (io_wr || io_rd) && io_addr[15:7] == 9'h003 |=> vdac_ctrl_bits == addr_q[5:0];
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("dac control bits wrong");
    property p_unmapped;
        io_rd && io_addr >= 16'h0380 |=> io_rdata_oe_n && io_rdata == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read driven");
endmodule
bind io_select_dma_gate_decoder io_select_props i_io_select_props (.clk, .rstn, .io_addr,
    .io_wr, .io_rd, .io_rdata, .io_rdata_oe_n, .sel_block_zero, .sel_expansion_b,
    .vdac_ctrl_bits, .vdac_en_q, .refresh_en_q, .dma_gate_q, .dma1_req_in, .dma1_req,
    .luma_adc);

// File: hold_responder.sv
// Processor side of the bus hold handshake
`timescale 1ns/1ns
module hold_responder (
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Hold handshake
    input wire [3:0] ack_delay,
    input wire bus_hold_req,
    output reg bus_hold_ack_pin
);
    reg [3:0] wait_q;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wait_q <= 4'h0;
            bus_hold_ack_pin <= 1'b0;
        end else if (!bus_hold_req) begin
            wait_q <= 4'h0;
            bus_hold_ack_pin <= 1'b0;
        end else if (wait_q >= ack_delay) begin
            bus_hold_ack_pin <= 1'b1;
        end else begin
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule

// File: tb_top.sv
// Testbench for the I/O select and DMA gate decoder
`timescale 1ns/1ns
module tb_top;
    reg clk = 1'b0;
    reg rstn = 1'b0;
    reg [15:0] io_addr = 16'h0000;
    reg [15:0] io_wdata = 16'h0000;
    reg io_wr = 1'b0;
    reg io_rd = 1'b0;
    reg [15:0] printer_status = 16'hA5C3;
    reg [15:0] gpio_in = 16'h3C5A;
    reg [15:0] video_position = 16'h0F1E;
    reg [15:0] luma_adc = 16'h7E81;
    reg dma0_req_in = 1'b1;
    reg dma1_req_in = 1'b1;
    reg [7:0] comparator_value = 8'h2D;
    reg [7:0] luminance_level = 8'hB4;
    reg [3:0] irq_pins = 4'h0;
    reg refresh_req_in = 1'b0;
    reg sync_pin = 1'b0;
    reg [3:0] ack_delay = 4'h0;
    wire [15:0] io_rdata, printer_data_q, printer_control_q, gpio_out_q, vdac_data_q;
    wire [15:0] line_load_word, synth_sync_period_q;
    wire [5:0] vdac_ctrl_bits;
    wire io_rdata_oe_n, sel_block_zero, sel_printer_port, sel_general_io, sel_vertical_dac_load;
    wire sel_scsi_board, sel_expansion_a, sel_expansion_b, vdac_data_load, vdac_en_q;
    wire refresh_en_q, dma_gate_q, dma0_req, dma1_req, crystal_line_ref, tick_irq;
    wire ext_irq_zero, ext_irq_one, ext_irq_three, ext_irq_four, bus_hold_ack_pin;
    wire bus_hold_req, line_table_refresh_cycle;
    integer err_count = 0;
    integer comparisons = 0;
    integer i;
    integer n;
    always #50 clk = ~clk;
    io_select_dma_gate_decoder #(.TICK_CYCLES(10), .LINE_REF_CYCLES(4)) i_io_select_dma_gate_decoder (
        .clk, .rstn, .io_addr, .io_wdata, .io_wr, .io_rd, .io_rdata, .io_rdata_oe_n,
        .sel_block_zero, .sel_printer_port, .sel_general_io, .sel_vertical_dac_load,
        .sel_scsi_board, .sel_expansion_a, .sel_expansion_b, .vdac_ctrl_bits, .printer_data_q,
        .printer_control_q, .printer_status, .gpio_in, .gpio_out_q, .vdac_data_q,
        .vdac_data_load, .video_position, .luma_adc, .vdac_en_q, .refresh_en_q, .dma_gate_q,
        .dma0_req_in, .dma1_req_in, .dma0_req, .dma1_req, .comparator_value, .luminance_level,
        .line_load_word, .synth_sync_pin(sync_pin), .synth_sync_period_q, .crystal_line_ref,
        .tick_irq, .printer_port_irq_pin(irq_pins[0]), .scsi_port_irq_pin(irq_pins[1]),
        .ext_irq_three_pin(irq_pins[2]), .ext_irq_four_pin(irq_pins[3]), .ext_irq_zero,
        .ext_irq_one, .ext_irq_three, .ext_irq_four, .refresh_req_in, .bus_hold_ack_pin,
        .bus_hold_req, .line_table_refresh_cycle);
    hold_responder i_hold_responder (.clk, .rstn, .ack_delay, .bus_hold_req, .bus_hold_ack_pin);
    task chk(input [15:0] e, input [15:0] s, input string nm);
        begin
            comparisons = comparisons + 1;
            if (s !== e) begin
                err_count = err_count + 1;
                $display("Error %0s expected %h seen %h", nm, e, s);
            end
        end
    endtask
    task wr(input [15:0] a, input [15:0] d);
        begin
            @(negedge clk);
            io_addr = a;
            io_wdata = d;
            io_wr = 1'b1;
            @(negedge clk);
            io_wr = 1'b0;
        end
    endtask
    task rd(input [15:0] a, input [15:0] e, input oe_n);
        begin
            @(negedge clk);
            io_addr = a;
            io_rd = 1'b1;
            @(negedge clk);
            io_rd = 1'b0;
            chk(e, io_rdata, "read data");
            chk({15'h0000, oe_n}, {15'h0000, io_rdata_oe_n}, "read enable");
        end
    endtask
    task complete_run;
        begin
            $display("Comparisons %0d errors %0d", comparisons, err_count);
            if (err_count == 0 && comparisons > 0) begin
                $display("Testbench passed");
            end else begin
                $display("Testbench failed");
            end
            $finish;
        end
    endtask
    task wait_hi(input integer which);
        reg v;
        begin
            v = crystal_line_ref;
            n = 0;
            while (!((which == 2) ? (crystal_line_ref !== v) :
                    ((which ? line_table_refresh_cycle : tick_irq) === 1'b1)) && n < 40) begin
                @(negedge clk);
                n = n + 1;
            end
            if (n >= 40) begin
                err_count = err_count + 1;
                $display("Error wait %0d expected %h seen %h", which, 1'b1, 1'b0);
                complete_run;
            end
        end
    endtask
    initial begin
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        chk(16'h0000, {15'h0000, dma_gate_q}, "gate reset");
        for (i = 0; i < 8; i = i + 1) begin
            @(negedge clk);
            io_addr = i * 128 + 68;
            io_rd = 1'b1;
            #1;
            chk((i < 7) ? (16'h0001 << i) : 16'h0000, {9'h000, sel_expansion_b, sel_expansion_a,
                sel_scsi_board, sel_vertical_dac_load, sel_general_io, sel_printer_port,
                sel_block_zero}, "selects");
        end
        rd(16'h03C4, 16'h0000, 1'b1);
        wr(16'h0002, 16'h0000);
        chk(16'h0003, {14'h0000, dma1_req, dma0_req}, "dma on");
        @(negedge clk);
        chk({luminance_level, comparator_value}, line_load_word, "load word");
        wr(16'h007D, 16'hFFFF);
        chk(16'h0000, {14'h0000, dma1_req, dma0_req}, "dma off");
        wr(16'h0080, 16'h1234);
        wr(16'h0082, 16'h4321);
        chk(16'h1234, printer_data_q, "printer data");
        chk(16'h4321, printer_control_q, "printer control");
        rd(16'h0080, printer_status, 1'b0);
        wr(16'h0100, 16'hBEEF);
        chk(16'hBEEF, gpio_out_q, "gpio out");
        rd(16'h0100, gpio_in, 1'b0);
        wr(16'h0108, 16'h0ACE);
        chk(16'h0001, {15'h0000, vdac_data_load}, "dac load");
        chk(16'h0ACE, vdac_data_q, "dac data");
        rd(16'h0108, video_position, 1'b0);
        rd(16'h0140, luma_adc, 1'b0);
        wr(16'h01AB, 16'h0000);
        chk(16'h002B, {10'h000, vdac_ctrl_bits}, "dac control");
        wr(16'h0118, 16'h0000);
        chk(16'h0001, {15'h0000, vdac_en_q}, "dac enable set");
        rd(16'h0118, 16'h0000, 1'b1);
        chk(16'h0000, {15'h0000, vdac_en_q}, "dac enable clear");
        for (i = 0; i < 4; i = i + 1) begin
            irq_pins = 4'h1 << i;
            repeat (3) @(negedge clk);
            chk(16'h0001 << i, {12'h000, ext_irq_four, ext_irq_three, ext_irq_one,
                ext_irq_zero}, "irq route");
        end
        wait_hi(0);
        @(negedge clk);
        wait_hi(0);
        chk(16'd9, n, "tick gap");
        wait_hi(2);
        wait_hi(2);
        chk(16'd4, n, "line ref gap");
        for (i = 0; i < 2; i = i + 1) begin
            ack_delay = i * 5;
            wr(16'h0120, 16'h0000);
            refresh_req_in = 1'b1;
            @(negedge clk);
            refresh_req_in = 1'b0;
            chk(16'h0001, {15'h0000, bus_hold_req}, "hold request");
            wait_hi(1);
            @(negedge clk);
            chk(16'h0000, {15'h0000, bus_hold_req}, "hold release");
            rd(16'h0120, 16'h0000, 1'b1);
            chk(16'h0000, {15'h0000, refresh_en_q}, "refresh clear");
        end
        for (i = 0; i < 3; i = i + 1) begin
            sync_pin = 1'b1;
            repeat (2) @(negedge clk);
            sync_pin = 1'b0;
            repeat (6) @(negedge clk);
        end
        chk(16'd8, synth_sync_period_q, "sync period");
        complete_run;
    end
endmodule
